// *** hw/processor_phase_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module processor_phase_sequencer
  import phase_seq_pkg::*;
#(
  parameter int CYCLE_DIV = CYCLE_CLKS
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire uinst_s            i_uinst,
  input  wire decode_s           i_decode,
  input  wire console_s          i_console,
  input  wire logic              i_illegal,
  input  wire logic              i_abort_safe,
  input  wire logic              i_abort_block,
  input  wire logic              i_abort_interrupt,
  input  wire logic              i_interrupt_pending,
  input  wire logic              i_status_load,
  input  wire logic              i_status_wait_bit,
  input  wire logic              i_mem_done,
  output logic [1:0]             o_phase,
  output logic [ADDR_W-1:0]      o_micro_addr,
  output logic                   o_cycle_en,
  output logic                   o_run_flag,
  output logic                   o_abort_enable_flag,
  output logic                   o_mem_read,
  output logic                   o_load_ir,
  output logic                   o_decoder_rom_load_strobe,
  output logic                   o_wait_state,
  output logic                   o_halt_mode
);

  typedef enum logic [3:0] {
    P0_IDLE   = 4'b0001,
    P0_FETCH1 = 4'b0010,
    P0_FETCH2 = 4'b0100,
    P0_ROUTE  = 4'b1000
  } p0_state_e;

  // instruction class, short form counts as register-register
  function automatic instr_class_e instr_class(input decode_s d);
    if (d.register_register_type) begin
      instr_class = CLASS_RR;
    end else if (d.register_storage_type) begin
      instr_class = CLASS_RS;
    end else begin
      instr_class = CLASS_RX;
    end
  endfunction

  // phase-one entry point for an address-modified instruction
  function automatic logic [ADDR_W-1:0] p1_entry(input decode_s d);
    if (instr_class(d) == CLASS_RS) begin
      p1_entry = ADDR_P1_RS;
    end else if (d.index_nonzero) begin
      p1_entry = ADDR_P1_RX_IDX;
    end else begin
      p1_entry = ADDR_P1_RX;
    end
  endfunction

  logic [CNT_W-1:0]  cyc_cnt_reg;
  logic              cycle_en_reg;
  logic [1:0]        phase_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              run_reg;
  logic              restore_reg;
  logic              p2_first_reg;
  logic              abort_en_reg;
  p0_state_e         p0_state_reg;
  logic              mem_read_reg;
  logic              load_ir_reg;
  logic              decoder_rom_strobe_reg;
  logic              wait_reg;
  logic              halt_reg;

  logic              do_pc;
  logic              go_illegal;
  logic              go_abort;
  logic              go_end_int;
  logic              go_p3;
  logic              leave_p3;
  logic              leave_p0;
  logic [ADDR_W-1:0] force_addr;

  // machine-cycle enable; clocks stay stopped while system clear is held
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_cnt_reg  <= '0;
      cycle_en_reg <= 1'b0;
    end else if (cyc_cnt_reg == CNT_W'(CYCLE_DIV - 1)) begin
      cyc_cnt_reg  <= '0;
      cycle_en_reg <= 1'b1;
    end else begin
      cyc_cnt_reg  <= cyc_cnt_reg + 1'b1;
      cycle_en_reg <= 1'b0;
    end
  end

  // phase-three entry causes, all looked at on the machine-cycle edge
  always_comb begin
    do_pc      = cycle_en_reg && i_uinst.is_do && i_uinst.phase_change_function;
    // only these three causes exist; arithmetic faults are not among them
    go_illegal = cycle_en_reg && phase_reg == PHASE_TWO && p2_first_reg
                 && i_illegal;
    go_abort   = cycle_en_reg && phase_reg == PHASE_TWO && abort_en_reg
                 && i_abort_interrupt;
    go_end_int = (do_pc && phase_reg == PHASE_TWO
                  && (i_interrupt_pending || i_console.single_step_switch))
                 || (cycle_en_reg && wait_reg
                     && (i_interrupt_pending || i_abort_interrupt));
    go_p3      = go_illegal || go_abort || go_end_int;
    // illegal first, then abort, then end-of-instruction interrupt
    if (go_illegal) begin
      force_addr = ADDR_ILLEGAL;
    end else if (go_abort) begin
      force_addr = ADDR_ABORT;
    end else begin
      force_addr = ADDR_END_INT;
    end
    // halt idles in phase three; otherwise a phase-change Do leaves here
    leave_p3   = do_pc && phase_reg == INTERRUPT_PHASE && !halt_reg;
    leave_p0   = cycle_en_reg && phase_reg == PHASE_ZERO && p0_state_reg == P0_ROUTE;
  end

  // phase count: a Do with phase change moves it, plus init, forced phase-three entries and phase zero exit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= INTERRUPT_PHASE;
    end else if (go_p3) begin
      phase_reg <= INTERRUPT_PHASE;
    end else if (leave_p3) begin
      phase_reg <= PHASE_ZERO;
    end else if (leave_p0) begin
      // hardware choice from decode, no micro-instruction field involved
      phase_reg <= i_decode.address_modify_flag ? PHASE_ONE : PHASE_TWO;
    end else if (do_pc && phase_reg == PHASE_ONE) begin
      phase_reg <= PHASE_TWO;
    end else if (do_pc && phase_reg == PHASE_TWO) begin
      phase_reg <= PHASE_ZERO;
    end
  end

  // micro-address: forced entries land on the same edge as the phase change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg <= ADDR_INIT;
    end else if (go_p3) begin
      addr_reg <= force_addr;
    end else if (leave_p0 && i_decode.address_modify_flag) begin
      addr_reg <= p1_entry(i_decode);
    end else if (leave_p0 || (do_pc && phase_reg == PHASE_ONE)) begin
      addr_reg <= i_decode.decoder_rom;
    end else if (cycle_en_reg && restore_reg) begin
      addr_reg <= ADDR_RESTORE;
    end else if (cycle_en_reg && phase_reg == PHASE_ZERO) begin
      addr_reg <= addr_reg; // phase zero runs no micro-routine
    end else if (cycle_en_reg && i_uinst.branch && !(do_pc && phase_reg == INTERRUPT_PHASE)) begin
      addr_reg <= i_uinst.target;
    end else if (cycle_en_reg) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // run flag sets on the first cycle after init; restore branch follows it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg     <= 1'b0;
      restore_reg <= 1'b0;
    end else if (cycle_en_reg) begin
      if (!run_reg && phase_reg == INTERRUPT_PHASE && addr_reg == ADDR_INIT) begin
        run_reg     <= 1'b1;
        restore_reg <= 1'b1;
      end else begin
        restore_reg <= 1'b0;
      end
    end
  end

  // marks the first micro-instruction of phase two
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p2_first_reg <= 1'b0;
    end else if (go_p3 || leave_p3) begin
      p2_first_reg <= 1'b0;
    end else if (leave_p0 && !i_decode.address_modify_flag) begin
      p2_first_reg <= 1'b1;
    end else if (do_pc && phase_reg == PHASE_ONE) begin
      p2_first_reg <= 1'b1;
    end else if (cycle_en_reg) begin
      p2_first_reg <= 1'b0;
    end
  end

  // abort enable; a blocking function in the same cycle keeps it clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      abort_en_reg <= 1'b0;
    end else if (go_p3 || (do_pc && phase_reg == PHASE_TWO)) begin
      abort_en_reg <= 1'b0;
    end else if (cycle_en_reg && phase_reg == PHASE_TWO && i_abort_block) begin
      abort_en_reg <= 1'b0;
    end else if (cycle_en_reg && p2_first_reg && i_abort_safe && !i_illegal) begin
      abort_en_reg <= 1'b1;
    end
  end

  // phase zero fetch sequencer; memory handshakes run at the full clock rate
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p0_state_reg <= P0_IDLE;
      mem_read_reg <= 1'b0;
      load_ir_reg  <= 1'b0;
    end else begin
      mem_read_reg <= 1'b0;
      load_ir_reg  <= 1'b0;
      case (p0_state_reg)
        P0_IDLE: begin
          if (leave_p3 || (do_pc && phase_reg == PHASE_TWO && !go_p3)) begin
            p0_state_reg <= P0_FETCH1;
            mem_read_reg <= 1'b1;
          end
        end
        P0_FETCH1: begin
          if (i_mem_done) begin
            load_ir_reg <= 1'b1; // first halfword into data and instruction regs
            if (i_decode.fullword) begin
              p0_state_reg <= P0_FETCH2;
              mem_read_reg <= 1'b1;
            end else begin
              p0_state_reg <= P0_ROUTE;
            end
          end
        end
        P0_FETCH2: begin
          if (i_mem_done) begin
            p0_state_reg <= P0_ROUTE;
          end
        end
        P0_ROUTE: begin
          if (leave_p0) begin
            p0_state_reg <= P0_IDLE;
          end
        end
        default: begin
          p0_state_reg <= P0_IDLE;
        end
      endcase
    end
  end

  // decoder ROM strobe on every entry to phase two from zero or one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      decoder_rom_strobe_reg <= 1'b0;
    end else begin
      decoder_rom_strobe_reg <= (leave_p0 && !i_decode.address_modify_flag)
                         || (do_pc && phase_reg == PHASE_ONE && !go_p3);
    end
  end

  // interruptible wait; a new status load with the bit set wins over the exit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg <= 1'b0;
    end else if (cycle_en_reg && phase_reg == PHASE_TWO && i_status_load) begin
      wait_reg <= i_status_wait_bit;
    end else if (go_end_int) begin
      wait_reg <= 1'b0;
    end
  end

  // halt mode: set by a console request with run up, left on a console request with run down
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_reg <= 1'b0;
    end else if (cycle_en_reg && phase_reg == INTERRUPT_PHASE
                 && i_console.console_attention_request) begin
      halt_reg <= i_console.run_switch_up;
    end
  end

  // outputs come straight from flops
  always_comb begin
    o_phase                   = phase_reg;
    o_micro_addr              = addr_reg;
    o_cycle_en                = cycle_en_reg;
    o_run_flag                = run_reg;
    o_abort_enable_flag       = abort_en_reg;
    o_mem_read                = mem_read_reg;
    o_load_ir                 = load_ir_reg;
    o_decoder_rom_load_strobe = decoder_rom_strobe_reg;
    o_wait_state              = wait_reg;
    o_halt_mode               = halt_reg;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_init_at_zero;
    !run_reg && cycle_en_reg && phase_reg == INTERRUPT_PHASE && addr_reg == ADDR_INIT;
  endsequence

  sequence s_step_then_restore;
    ##1 (addr_reg == ADDR_INIT_STEP && run_reg) ##[1:20] (addr_reg == ADDR_RESTORE);
  endsequence

  AST_PHASE_ONLY_ON_CYCLE:
    assert property ((phase_reg != $past(phase_reg)) |-> $past(cycle_en_reg))
      else $error("phase changed outside a machine-cycle edge");

  AST_INIT_SEQUENCE:
    assert property (s_init_at_zero |-> s_step_then_restore)
      else $error("init did not step to 01 and branch to restore");

  AST_ILLEGAL_ENTRY:
    assert property (go_illegal |=> phase_reg == INTERRUPT_PHASE && addr_reg == ADDR_ILLEGAL)
      else $error("illegal instruction did not force entry at 100");

  AST_ABORT_ENTRY:
    assert property (go_abort && !go_illegal |=> phase_reg == INTERRUPT_PHASE
                     && addr_reg == ADDR_ABORT)
      else $error("abort did not force entry at 0a");

  AST_END_INT_ENTRY:
    assert property (go_end_int && !go_abort && !go_illegal |=> addr_reg == ADDR_END_INT)
      else $error("end interrupt did not force entry at 010");

  AST_P3_EXIT_TO_P0:
    assert property (leave_p3 |=> phase_reg == PHASE_ZERO && mem_read_reg)
      else $error("phase three exit did not reach phase zero with a fetch");

  AST_P0_ROUTE:
    assert property (leave_p0 |=> phase_reg == ($past(i_decode.address_modify_flag)
                     ? PHASE_ONE : PHASE_TWO))
      else $error("phase zero exit took wrong phase");

  AST_DECODER_ROM_STROBE:
    assert property (leave_p0 && !i_decode.address_modify_flag
                     |=> decoder_rom_strobe_reg && addr_reg == $past(i_decode.decoder_rom))
      else $error("decoder rom not loaded on entry to phase two");

  AST_ABORT_BLOCK:
    assert property (cycle_en_reg && phase_reg == PHASE_TWO && i_abort_block |=> !abort_en_reg)
      else $error("abort enable survived a blocking function");

  AST_FULLWORD_FETCH:
    assert property (p0_state_reg == P0_FETCH1 && i_mem_done && i_decode.fullword
                     |=> mem_read_reg && p0_state_reg == P0_FETCH2)
      else $error("second halfword not requested");

endmodule

`default_nettype wire

// *** hw/phase_seq_pkg.sv ***
package phase_seq_pkg;

  // micro-address width and timing
  localparam int          ADDR_W        = 12;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          CYCLE_NS      = 250;
  localparam int          CYCLE_CLKS    = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 4;

  // phase numbers, binary value equals the phase
  localparam logic [1:0]  PHASE_ZERO      = 2'h0;
  localparam logic [1:0]  PHASE_ONE       = 2'h1;
  localparam logic [1:0]  PHASE_TWO       = 2'h2;
  localparam logic [1:0]  INTERRUPT_PHASE = 2'h3;

  // forced micro-addresses
  localparam logic [11:0] ADDR_INIT      = 12'h000;
  localparam logic [11:0] ADDR_INIT_STEP = 12'h001;
  localparam logic [11:0] ADDR_RESTORE   = 12'h0b6;
  localparam logic [11:0] ADDR_ILLEGAL   = 12'h100;
  localparam logic [11:0] ADDR_ABORT     = 12'h00a;
  localparam logic [11:0] ADDR_END_INT   = 12'h010;
  localparam logic [11:0] ADDR_P1_RS     = 12'h002;
  localparam logic [11:0] ADDR_P1_RX     = 12'h004;
  localparam logic [11:0] ADDR_P1_RX_IDX = 12'h006;

  // instruction classes from decoding
  typedef enum logic [1:0] {
    CLASS_RR = 2'h0,
    CLASS_RS = 2'h1,
    CLASS_RX = 2'h2
  } instr_class_e;

  // micro-instruction ending in this machine cycle
  typedef struct packed {
    logic              is_do;
    logic              phase_change_function;
    logic              branch;
    logic [ADDR_W-1:0] target;
  } uinst_s;

  // instruction decode terms
  typedef struct packed {
    logic              address_modify_flag;
    logic              register_register_type;
    logic              register_storage_type;
    logic              fullword;
    logic              index_nonzero;
    logic [ADDR_W-1:0] decoder_rom;
  } decode_s;

  // console controls
  typedef struct packed {
    logic console_attention_request;
    logic single_step_switch;
    logic run_switch_up;
    logic execute_button;
  } console_s;

endpackage

// *** sim/core_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// core memory stand-in: one done pulse for each read request, after a set delay
module core_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_mem_read,
  input  wire logic [3:0] i_delay,
  output logic            o_mem_done,
  output logic [7:0]      o_reads
);
  logic [3:0] cnt_reg;
  logic       busy_reg;

  // never answers unasked, so a spurious load shows up as a wrong count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg    <= 4'h0;
      busy_reg   <= 1'b0;
      o_mem_done <= 1'b0;
    end else begin
      o_mem_done <= 1'b0;
      if (i_mem_read) begin
        busy_reg <= 1'b1;
        cnt_reg  <= i_delay;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg   <= 1'b0;
        o_mem_done <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  // request count lets the bench tell one fetch from two
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reads <= 8'h00;
    end else if (i_mem_read) begin
      o_reads <= o_reads + 8'h01;
    end
  end
endmodule

`default_nettype wire

// *** sim/processor_phase_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module processor_phase_sequencer_tb
  import phase_seq_pkg::*;
;
  logic              i_clk;
  logic              i_rst_n;
  uinst_s            u;
  decode_s           d;
  console_s          c;
  logic              ill, safe, blk, aint, ipend, sload, sbit;
  logic              mem_done, o_mem_read, o_load_ir, rom_stb;
  logic              o_cycle_en, o_run_flag, o_abort, o_wait, o_halt;
  logic [1:0]        o_phase;
  logic [ADDR_W-1:0] o_micro_addr;
  logic [3:0]        dly;
  logic [7:0]        reads;
  int                err_count;
  int                n_compared;
  int                n_ir = 0;

  // short machine cycle keeps the run brief
  processor_phase_sequencer #(.CYCLE_DIV(3)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_uinst(u), .i_decode(d), .i_console(c),
    .i_illegal(ill), .i_abort_safe(safe), .i_abort_block(blk),
    .i_abort_interrupt(aint), .i_interrupt_pending(ipend), .i_status_load(sload),
    .i_status_wait_bit(sbit), .i_mem_done(mem_done), .o_phase(o_phase),
    .o_micro_addr(o_micro_addr), .o_cycle_en(o_cycle_en), .o_run_flag(o_run_flag),
    .o_abort_enable_flag(o_abort), .o_mem_read(o_mem_read), .o_load_ir(o_load_ir),
    .o_decoder_rom_load_strobe(rom_stb), .o_wait_state(o_wait), .o_halt_mode(o_halt));

  core_mem_model mem (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem_read(o_mem_read), .i_delay(dly),
    .o_mem_done(mem_done), .o_reads(reads));

  // counts instruction register loads, one per fetched instruction
  always @(posedge i_clk) begin
    if (o_load_ir === 1'b1) n_ir <= n_ir + 1;
  end

  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic give_up;
    $display("ERROR timeout expected progress seen none");
    err_count++;
    complete_run();
  endtask

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  task automatic chk_pa(input logic [1:0] ep, input logic [11:0] ea);
    chk("phase", 12'(o_phase), 12'(ep));
    chk("micro_addr", o_micro_addr, ea);
  endtask

  // one micro-instruction, taken at the edge where the cycle enable is high
  task automatic mc(input logic dd, input logic pp);
    int n;
    u <= '{dd, pp, 1'b0, 12'h000};
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_cycle_en !== 1'b1 && n < 20);
    if (n == 20) give_up();
    @(posedge i_clk);
    u <= '0;
    @(negedge i_clk);
  endtask

  task automatic wait_ph(input logic [1:0] e);
    int n;
    n = 0;
    while (o_phase !== e && n < 80) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 80) give_up();
  endtask

  // f = {address modify, reg-reg, reg-storage, fullword, index nonzero}
  task automatic fetch(input logic [4:0] f, input logic [3:0] dl);
    logic [11:0] ea;
    logic [7:0]  r0;
    int          ir0;
    ea = !f[4] ? 12'h3c5 : f[2] ? 12'h002 : f[0] ? 12'h006 : 12'h004;
    ir0 = n_ir;
    d <= '{f[4], f[3], f[2], f[1], f[0], 12'h3c5};
    dly <= dl;
    r0 = reads;
    mc(1'b1, 1'b1);
    chk("phase", 12'(o_phase), 12'h000);
    chk("mem_read", 12'(o_mem_read), 12'h001);
    wait_ph(f[4] ? 2'h1 : 2'h2);
    chk("entry_addr", o_micro_addr, ea);
    chk("rom_strobe", 12'(rom_stb), 12'(!f[4]));
    chk("reads", 12'(reads - r0), f[1] ? 12'h002 : 12'h001);
    chk("load_ir", 12'(n_ir - ir0), 12'h001);
  endtask

  initial begin
    logic [4:0] tbl [5];
    tbl = '{5'b01000, 5'b10110, 5'b10010, 5'b10011, 5'b00010};
    err_count = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    u = '0;
    d = '0;
    c = '0;
    {ill, safe, blk, aint, ipend, sload, sbit} = 7'h00;
    dly = 4'h1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk_pa(2'h3, 12'h000);
    chk("flags", {7'h00, o_run_flag, o_abort, o_wait, o_halt, rom_stb}, 12'h000);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    mc(1'b0, 1'b0);
    chk("init_addr", o_micro_addr, 12'h001);
    chk("run_flag", 12'(o_run_flag), 12'h001);
    mc(1'b0, 1'b0);
    chk_pa(2'h3, 12'h0b6);
    $display("test init done");
    // halt holds phase three against a phase-change Do
    c <= '{1'b1, 1'b0, 1'b1, 1'b0};
    mc(1'b0, 1'b0);
    chk("halt", 12'(o_halt), 12'h001);
    c <= '0;
    mc(1'b1, 1'b1);
    chk("phase", 12'(o_phase), 12'h003);
    c <= '{1'b1, 1'b0, 1'b0, 1'b1};
    mc(1'b0, 1'b0);
    chk("halt", 12'(o_halt), 12'h000);
    c <= '0;
    mc(1'b1, 1'b0);
    chk("phase", 12'(o_phase), 12'h003);
    $display("test halt done");
    foreach (tbl[i]) begin
      fetch(tbl[i], i[0] ? 4'h6 : 4'h1);
      if (tbl[i][4]) begin
        mc(1'b1, 1'b1);
        chk("phase", 12'(o_phase), 12'h002);
      end
    end
    $display("test fetch done");
    // abort enable set, then blocked, then armed again and used
    safe <= 1'b1;
    mc(1'b0, 1'b0);
    chk("abort_en", 12'(o_abort), 12'h001);
    safe <= 1'b0;
    blk <= 1'b1;
    mc(1'b0, 1'b0);
    chk("abort_en", 12'(o_abort), 12'h000);
    blk <= 1'b0;
    aint <= 1'b1;
    mc(1'b0, 1'b0);
    chk("phase", 12'(o_phase), 12'h002);
    aint <= 1'b0;
    fetch(5'b01000, 4'h1);
    safe <= 1'b1;
    mc(1'b0, 1'b0);
    safe <= 1'b0;
    aint <= 1'b1;
    mc(1'b0, 1'b0);
    chk_pa(2'h3, 12'h00a);
    aint <= 1'b0;
    $display("test abort done");
    fetch(5'b01000, 4'h6);
    {ill, safe, aint} <= 3'h7;
    mc(1'b0, 1'b0);
    chk_pa(2'h3, 12'h100);
    {ill, safe, aint} <= 3'h0;
    $display("test illegal done");
    for (int k = 0; k < 2; k++) begin
      fetch(5'b01000, 4'h1);
      if (k == 0) ipend <= 1'b1;
      else c <= '{1'b0, 1'b1, 1'b0, 1'b0};
      mc(1'b1, 1'b1);
      chk_pa(2'h3, 12'h010);
      ipend <= 1'b0;
      c <= '0;
    end
    $display("test end_interrupt done");
    fetch(5'b01000, 4'h1);
    {sload, sbit} <= 2'h3;
    mc(1'b0, 1'b0);
    chk("wait", 12'(o_wait), 12'h001);
    {sload, sbit} <= 2'h0;
    mc(1'b0, 1'b0);
    chk("phase", 12'(o_phase), 12'h002);
    ipend <= 1'b1;
    mc(1'b0, 1'b0);
    chk_pa(2'h3, 12'h010);
    chk("wait", 12'(o_wait), 12'h000);
    ipend <= 1'b0;
    $display("test wait done");
    // system clear in mid-run
    fetch(5'b01000, 4'h1);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    chk_pa(2'h3, 12'h000);
    chk("flags", {9'h000, o_run_flag, o_abort, o_halt}, 12'h000);
    $display("test clear done");
    complete_run();
  end
endmodule

`default_nettype wire
